//--- ccr_ctl0.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
// Mode control register 0 with mode handshakes, stamp timer and interrupt
//
// Contract
// - Init mode holds register at reset values, except wake enable and sleep request, which keep theirs
// - Writes accepted again after init exits
// - Status bits read-only, flag module-set only
// - Valid received message sets frame flag
// - Flag cleared by writing one only
// - Frame flag, receiver active invalid in loopback
// - Receiver active while receiving, not transmitting
// - Receiver active driven by receiver front end
// - Stop-in-wait gates bus interface clocks
// - Synchronized bit reflects bus synchronization
// - Timer enable starts bit-time counter
// - Acknowledge stores stamp into message buffer
// - Clearing timer enable zeroes counter
// - Timer enable forced low in init
// - Wake enable lets traffic end sleep
// - Init request aborts transfer, acknowledged
// - Sleep only when idle, acknowledged
module ccr_ctl0
   import ccr_pkg::*;
#(
   parameter int STAMP_W = 16,
   parameter int BIT_CYC = CCR_BIT_CYC
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Protocol engine status
   input wire logic rx_frame_ok_in,
   input wire logic rx_busy_in,
   input wire logic bus_synced_in,
   input wire logic bus_idle_in,
   input wire logic tx_empty_in,
   input wire logic bus_traffic_in,
   input wire logic msg_ack_in,
   input wire logic loopback_in,
   input wire logic cpu_wait_in,
   // Engine controls
   output logic abort_out,
   output logic bus_clk_stop_out,
   output logic stamp_we_out,
   output logic [STAMP_W-1:0] stamp_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   // Control bits live in flops; status bits are read straight
   // from the engine or from the sticky flags
   logic stopw_q;           // Stop-in-wait control
   logic timer_q;           // Timer enable
   logic wake_q;            // Wake on traffic enable
   logic wake_arm_q;        // Wake enable latched at sleep entry
   logic sleep_request_q;           // Sleep request
   logic init_request_q;          // Init request
   logic [2:0] imask_q;     // Interrupt mask
   logic [7:0] rdata_q;     // Registered read data
   ccr_mode_e mode_q;       // Mode state
   ccr_mode_e mode_d;
   logic in_init;           // Init request and acknowledge both set
   logic init_ak;
   logic slp_ak;
   logic wr_ctl0;
   logic wr_mask;
   logic rd_stat;
   logic can_write;
   logic frame_set;
   logic frame_flag;
   logic rx_act;
   logic sync_now;
   logic sync_q;            // Previous sync level for edge event
   logic wake_evt;
   logic [2:0] ievt;
   logic [2:0] istat;
   logic [STAMP_W-1:0] count;
   logic [7:0] ctl0_val;
   logic [7:0] ctl1_val;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   // Strobes qualified by the register index. Unmapped indices
   // match nothing, so stray writes are dropped and stray reads
   // return zero. Writes to control 0 are gated separately by
   // the init handshake below.
   assign wr_ctl0 = wr_in & (addr_in == CCR_OFS_CTL0);
   assign wr_mask = wr_in & (addr_in == CCR_OFS_IRQ_MASK);
   assign rd_stat = rd_in & (addr_in == CCR_OFS_IRQ_STAT);
   assign init_ak = (mode_q == CCR_INIT);
   assign slp_ak = (mode_q == CCR_SLEEP);
   assign in_init = init_request_q & init_ak;
   // Writes only once request and acknowledge both read zero
   assign can_write = ~init_request_q & ~init_ak;

   ////////////////////////////////////////////////////////////////////////
   // Status bits from the protocol engine
   // Receiver-active and synchronized are views of engine levels,
   // never stored here, so software has no path to alter them.
   // Both read zero in init mode because both are gated off
   // by the init state there.
   // Loopback frames do not count as bus reception
   assign frame_set = rx_frame_ok_in & ~loopback_in & ~in_init;
   assign rx_act = rx_busy_in & ~loopback_in & ~in_init;
   assign sync_now = bus_synced_in & ~in_init & ~slp_ak;
   // Traffic ends sleep only if wake was armed at entry
   assign wake_evt = slp_ak & wake_arm_q & bus_traffic_in;

   // Received-frame flag: write one clears, zero ignored
   ccr_sticky u_frame (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .set_in(frame_set),
      .clr_in(wr_ctl0 & can_write & wdata_in[CCR_B_FRAME_RECEIVED_FLAG]),
      .hold_in(in_init),
      .flag_out(frame_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode state machine
   // Run, init and sleep are one-hot. Init always wins over sleep,
   // since an init request aborts whatever the engine is doing.
   // Sleep is only entered with the bus quiet and nothing queued,
   // so no frame is ever cut by a sleep request.
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         CCR_RUN: begin
            if (init_request_q) begin
               mode_d = CCR_INIT;
            end else if (sleep_request_q & bus_idle_in & ~rx_busy_in & tx_empty_in) begin
               mode_d = CCR_SLEEP;
            end
         end
         CCR_INIT: begin
            if (!init_request_q) begin
               mode_d = CCR_RUN;
            end
         end
         CCR_SLEEP: begin
            if (init_request_q) begin
               mode_d = CCR_INIT;
            end else if (!sleep_request_q || wake_evt) begin
               mode_d = CCR_RUN;
            end
         end
         default: begin
            mode_d = CCR_RUN;
         end
      endcase
   end

   // Abort transfers while init is requested
   // Raised straight from the request bit, not the acknowledge,
   // so the engine stops before init mode is confirmed
   assign abort_out = init_request_q;

   ////////////////////////////////////////////////////////////////////////
   // Mode and control registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q <= CCR_INIT;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Init request: writable in any mode, cleared only once acknowledged
   // A clear written before the acknowledge is dropped; software
   // must poll the acknowledge before leaving init, or the mode
   // handshake could be torn in half
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         init_request_q <= CCR_CTL0_RST[CCR_B_INIT_REQUEST];
      end else if (wr_ctl0) begin
         // Set any time; clear only after acknowledge
         if (wdata_in[CCR_B_INIT_REQUEST] || init_ak) begin
            init_request_q <= wdata_in[CCR_B_INIT_REQUEST];
         end
      end
   end

   // Sleep request: wake clears it, clear only after acknowledge
   // Wake-up has priority over a write in the same cycle, so a
   // rewrite of the old value cannot put the block back to sleep
   // behind the engine's back
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sleep_request_q <= CCR_CTL0_RST[CCR_B_SLEEP_REQUEST];
      end else if (wake_evt) begin
         sleep_request_q <= 1'b0;
      end else if (wr_ctl0 & can_write) begin
         if (wdata_in[CCR_B_SLEEP_REQUEST] || slp_ak) begin
            sleep_request_q <= wdata_in[CCR_B_SLEEP_REQUEST];
         end
      end
   end

   // Ordinary control bits: held in reset during init
   // Init hold beats any write, so a write landing in the same
   // cycle as the acknowledge is lost; software writes these bits
   // only after both handshake bits read zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stopw_q <= CCR_CTL0_RST[CCR_B_STOPW];
         timer_q <= CCR_CTL0_RST[CCR_B_TIMER];
      end else if (in_init) begin
         stopw_q <= CCR_CTL0_RST[CCR_B_STOPW];
         timer_q <= 1'b0;
      end else if (wr_ctl0 & can_write) begin
         stopw_q <= wdata_in[CCR_B_STOPW];
         timer_q <= wdata_in[CCR_B_TIMER];
      end
   end

   // Wake enable kept through init; latched on sleep entry
   // The latched copy gates wake-up; a change to the enable
   // while asleep only takes effect at the next sleep entry
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wake_q <= CCR_CTL0_RST[CCR_B_WAKE];
         wake_arm_q <= 1'b0;
      end else begin
         if (wr_ctl0 & can_write) begin
            wake_q <= wdata_in[CCR_B_WAKE];
         end
         if (mode_q != CCR_SLEEP && mode_d == CCR_SLEEP) begin
            wake_arm_q <= wake_q;
         end
      end
   end

   // Bus interface clocks stopped in wait when enabled
   // Combinational so the gate follows the wait level at once;
   // the clock gate itself sits outside this block
   assign bus_clk_stop_out = stopw_q & cpu_wait_in;

   ////////////////////////////////////////////////////////////////////////
   // Time stamp
   // Counter runs from the bit-time prescaler; disabling it, or
   // init mode forcing the enable low, zeroes both stages so the
   // next run starts from zero
   ccr_stamp_timer #(
      .WIDTH(STAMP_W),
      .BIT_CYC(BIT_CYC)
   ) u_timer (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .enable_in(timer_q),
      .count_out(count)
   );

   // Capture stamp on acknowledge for the message buffer
   // The write pulse lags the acknowledge by one cycle and the
   // stamp holds until the next acknowledged message
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stamp_out <= '0;
         stamp_we_out <= 1'b0;
      end else begin
         stamp_we_out <= msg_ack_in & timer_q;
         if (msg_ack_in & timer_q) begin
            stamp_out <= count;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: frame, sync gained, wake-up
   // Sync raises an event only on a rising level, so a steady
   // synchronized bus does not keep refilling the status bit.
   // Previous level resets low so a bus already synced counts once
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync_q <= 1'b0;
         imask_q <= CCR_IRQ_RST;
      end else begin
         sync_q <= sync_now;
         if (wr_mask) begin
            imask_q <= wdata_in[2:0];
         end
      end
   end

   assign ievt[CCR_I_FRAME] = frame_set;
   assign ievt[CCR_I_SYNC] = sync_now & ~sync_q;
   assign ievt[CCR_I_WAKE] = wake_evt;

   // Sticky status bits, cleared by reading them
   // A new event in the read cycle wins over the clear, so an
   // event is never lost between the read and the next poll.
   // All three share the one read strobe of the status index.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_irq
         ccr_sticky u_ist (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .set_in(ievt[gi]),
            .clr_in(rd_stat),
            .hold_in(1'b0),
            .flag_out(istat[gi])
         );
      end
   endgenerate

   assign irq_out = |(istat & imask_q);

   ////////////////////////////////////////////////////////////////////////
   // Read back
   // Index decode for the read mux; ctl1 carries only the two
   // handshake acknowledges, both read-only
   assign ctl0_val = {frame_flag, rx_act, stopw_q, sync_now, timer_q,
                      wake_q, sleep_request_q, init_request_q};
   assign ctl1_val = {6'h00, slp_ak, init_ak};
   assign rd_mux = (addr_in == CCR_OFS_CTL0) ? ctl0_val :
                   (addr_in == CCR_OFS_CTL1) ? ctl1_val :
                   (addr_in == CCR_OFS_IRQ_STAT) ? {5'h00, istat} :
                   (addr_in == CCR_OFS_IRQ_MASK) ? {5'h00, imask_q} :
                   (addr_in == CCR_OFS_STAMP_LO) ? stamp_out[7:0] :
                   (addr_in == CCR_OFS_STAMP_HI) ? stamp_out[15:8] :
                   8'h00;

   // Read data valid the cycle after the strobe only
   // Zero outside the read slot so a bus that ORs slave data
   // together sees nothing from this block when idle
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_in ? rd_mux : 8'h00;
      end
   end
   assign rdata_out = rdata_q;
endmodule : ccr_ctl0

//--- ccr_pkg.sv
// Package: offsets, bit positions, reset values and timing for the control register
package ccr_pkg;
   // Register offsets (word index on the plain register port)
   localparam logic [3:0] CCR_OFS_CTL0 = 4'h0;
   localparam logic [3:0] CCR_OFS_CTL1 = 4'h1;
   localparam logic [3:0] CCR_OFS_IRQ_STAT = 4'h2;
   localparam logic [3:0] CCR_OFS_IRQ_MASK = 4'h3;
   localparam logic [3:0] CCR_OFS_STAMP_LO = 4'h4;
   localparam logic [3:0] CCR_OFS_STAMP_HI = 4'h5;
   // Mode control 0 bit positions
   localparam int CCR_B_FRAME_RECEIVED_FLAG = 7;
   localparam int CCR_B_RECEIVER_ACTIVE = 6;
   localparam int CCR_B_STOPW = 5;
   localparam int CCR_B_SYNC = 4;
   localparam int CCR_B_TIMER = 3;
   localparam int CCR_B_WAKE = 2;
   localparam int CCR_B_SLEEP_REQUEST = 1;
   localparam int CCR_B_INIT_REQUEST = 0;
   // Mode control 1 (status) bit positions
   localparam int CCR_B_SLEEP_ACKNOWLEDGE = 1;
   localparam int CCR_B_INIT_ACKNOWLEDGE = 0;
   // Interrupt status bit positions
   localparam int CCR_I_FRAME = 0;
   localparam int CCR_I_SYNC = 1;
   localparam int CCR_I_WAKE = 2;
   // Reset values
   localparam logic [7:0] CCR_CTL0_RST = 8'h01;
   localparam logic [2:0] CCR_IRQ_RST = 3'h0;
   // Bit time default: 1 us at 100 MHz clock
   localparam int CCR_CLK_NS = 10;
   localparam int CCR_BIT_NS = 1000;
   localparam int CCR_BIT_CYC = (CCR_BIT_NS / CCR_CLK_NS < 1) ? 1 :
                                CCR_BIT_NS / CCR_CLK_NS;
   // Mode states
   typedef enum logic [2:0] {
      CCR_RUN = 3'b001,
      CCR_INIT = 3'b010,
      CCR_SLEEP = 3'b100
   } ccr_mode_e;
endpackage : ccr_pkg

//--- ccr_sticky.sv
`timescale 1ns/1ns
// Sticky flag: hardware set wins over clear
module ccr_sticky (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic set_in,
   input wire logic clr_in,
   input wire logic hold_in,
   output logic flag_out
);
   // Flag storage
   logic flag_q;
   logic flag_d;
   // Hold forces reset value; set beats clear
   assign flag_d = hold_in ? 1'b0 : (set_in | (flag_q & ~clr_in));
   // Flag register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
   assign flag_out = flag_q;
endmodule : ccr_sticky

//--- ccr_stamp_timer.sv
`timescale 1ns/1ns
// Free-running bit-time counter for message time stamps
module ccr_stamp_timer #(
   parameter int WIDTH = 16,
   parameter int BIT_CYC = 100
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic enable_in,
   output logic [WIDTH-1:0] count_out
);
   // Prescaler and counter
   logic [15:0] pre_q;
   logic [15:0] pre_d;
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic tick;
   // One tick per bit time
   assign tick = (pre_q == 16'(BIT_CYC - 1));
   // Disabled clears both to zero
   assign pre_d = !enable_in ? 16'h0000 : (tick ? 16'h0000 : pre_q + 16'h0001);
   assign cnt_d = !enable_in ? '0 : (tick ? cnt_q + 1'b1 : cnt_q);
   // Counter registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre_q <= 16'h0000;
         cnt_q <= '0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
      end
   end
   assign count_out = cnt_q;
endmodule : ccr_stamp_timer

//--- ccr_ctl0_sva.sv
`timescale 1ns/1ns
// Checker: port-level assertions for mode control register 0
module ccr_ctl0_chk
   import ccr_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic rx_frame_ok_in,
   input wire logic rx_busy_in,
   input wire logic msg_ack_in,
   input wire logic loopback_in,
   input wire logic cpu_wait_in,
   input wire logic abort_out,
   input wire logic bus_clk_stop_out,
   input wire logic stamp_we_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////
   // Decoded register accesses
   wire logic rd_ctl = rd_in && addr_in == CCR_OFS_CTL0;
   wire logic wr_ctl = wr_in && addr_in == CCR_OFS_CTL0;
   // Init request held long enough for the acknowledge
   sequence init_steady;
      abort_out [*4];
   endsequence
   // Running, a valid frame, one cycle with no write, then a read
   sequence frame_then_read;
      !abort_out ##1 !abort_out ##1
      (!abort_out && rx_frame_ok_in && !loopback_in) ##1 !wr_ctl ##1 rd_ctl;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   wait_gate_a: assert property (!cpu_wait_in |-> !bus_clk_stop_out)
      else $error("clock stopped outside wait");
   init_gate_a: assert property (init_steady |-> !bus_clk_stop_out)
      else $error("clock stop enabled in init");
   init_read_a: assert property (
      init_steady ##0 rd_ctl |=> rdata_out[7:3] == 5'h00)
      else $error("register not at reset in init");
   init_stamp_a: assert property (
      init_steady ##0 msg_ack_in |=> !stamp_we_out)
      else $error("stamp written in init");
   stamp_cause_a: assert property (stamp_we_out |-> $past(msg_ack_in))
      else $error("stamp write without acknowledge");
   init_keep_a: assert property (abort_out && !wr_ctl |=> abort_out)
      else $error("init request dropped");
   init_set_a: assert property (wr_ctl && wdata_in[0] |=> abort_out)
      else $error("init request not taken");
   frame_set_a: assert property (frame_then_read |=> rdata_out[7])
      else $error("frame flag not set");
endmodule : ccr_ctl0_chk

//--- ccr_bus_model.sv
`timescale 1ns/1ns
// Far-side bus model: turns bench requests into engine event pulses
module ccr_bus_model (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] go_in,
   output logic rx_frame_ok_out,
   output logic msg_ack_out,
   output logic bus_traffic_out
);
   // One-cycle events, quiet while in reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_frame_ok_out <= 1'b0;
         msg_ack_out <= 1'b0;
         bus_traffic_out <= 1'b0;
      end else begin
         rx_frame_ok_out <= go_in[0];
         msg_ack_out <= go_in[1];
         bus_traffic_out <= go_in[2];
      end
   end
endmodule : ccr_bus_model

//--- ccr_tb.sv
`timescale 1ns/1ns
// Self-checking bench for mode control register 0
module testbench
   import ccr_pkg::*;
;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
   logic rx_busy_in = 1'b0, bus_synced_in = 1'b0, bus_idle_in = 1'b1;
   logic tx_empty_in = 1'b1, loopback_in = 1'b0, cpu_wait_in = 1'b0;
   logic [2:0] go = 3'h0;
   logic rx_frame_ok_in, msg_ack_in, bus_traffic_in, abort_out;
   logic bus_clk_stop_out, stamp_we_out, irq_out;
   logic [7:0] rdata_out;
   logic [15:0] stamp_out;
   logic [7:0] exp_q[$];
   int bad_count = 0, n_tests = 0, k;
   always #5 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////
   ccr_bus_model u_bus (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go),
      .rx_frame_ok_out(rx_frame_ok_in), .msg_ack_out(msg_ack_in),
      .bus_traffic_out(bus_traffic_in));
   ccr_ctl0 #(.BIT_CYC(4)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .rx_frame_ok_in(rx_frame_ok_in),
      .rx_busy_in(rx_busy_in), .bus_synced_in(bus_synced_in),
      .bus_idle_in(bus_idle_in), .tx_empty_in(tx_empty_in),
      .bus_traffic_in(bus_traffic_in), .msg_ack_in(msg_ack_in),
      .loopback_in(loopback_in), .cpu_wait_in(cpu_wait_in),
      .abort_out(abort_out), .bus_clk_stop_out(bus_clk_stop_out),
      .stamp_we_out(stamp_we_out), .stamp_out(stamp_out), .irq_out(irq_out));
   ////////////////////////////////////////////////////////////////////////
   // Compare a level output
   task automatic cmp_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit
   // Compare read data
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : cmp_rd
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   // One-cycle register read, expectation queued
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask : rd
   // Ask the bus model for events, settle past their effect
   task automatic pulse(input logic [2:0] m);
      @(posedge clk_in);
      go <= m;
      @(posedge clk_in);
      go <= 3'h0;
      @(posedge clk_in);
      @(negedge clk_in);
   endtask : pulse
   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////
   // Read data checked in the slot after the strobe
   always @(posedge clk_in) rd_d <= rd_in;
   always @(negedge clk_in) if (rd_d) cmp_rd(rdata_out, exp_q.pop_front());
   // Watchdog
   initial begin
      repeat (3000) @(posedge clk_in);
      bad_count++;
      stop_test();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h119e));
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(CCR_OFS_CTL0, CCR_CTL0_RST);
      cmp_bit(abort_out, 1'b1);
      wr(CCR_OFS_CTL0, 8'hfd);
      rd(CCR_OFS_CTL0, 8'h01);
      wr(CCR_OFS_CTL0, 8'h00);
      repeat (2) @(negedge clk_in);
      cmp_bit(abort_out, 1'b0);
      wr(CCR_OFS_CTL0, 8'hec);
      rd(CCR_OFS_CTL0, 8'h2c);
      cpu_wait_in <= 1'b1;
      @(negedge clk_in);
      cmp_bit(bus_clk_stop_out, 1'b1);
      wr(CCR_OFS_CTL0, 8'h0c);
      @(negedge clk_in);
      cmp_bit(bus_clk_stop_out, 1'b0);
      @(posedge clk_in);
      cpu_wait_in <= 1'b0;
      rx_busy_in <= 1'b1;
      bus_synced_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd(CCR_OFS_CTL0, 8'h5c);
      rx_busy_in <= 1'b0;
      bus_synced_in <= 1'b0;
      pulse(3'h1);
      rd(CCR_OFS_CTL0, 8'h8c);
      wr(CCR_OFS_CTL0, 8'h0c);
      rd(CCR_OFS_CTL0, 8'h8c);
      wr(CCR_OFS_CTL0, 8'h8c);
      rd(CCR_OFS_CTL0, 8'h0c);
      rd(CCR_OFS_IRQ_STAT, 8'h03);
      rd(CCR_OFS_IRQ_STAT, 8'h00);
      loopback_in <= 1'b1;
      pulse(3'h1);
      rd(CCR_OFS_CTL0, 8'h0c);
      loopback_in <= 1'b0;
      wr(CCR_OFS_IRQ_MASK, 8'h01);
      pulse(3'h1);
      cmp_bit(irq_out, 1'b1);
      rd(CCR_OFS_IRQ_STAT, 8'h01);
      @(negedge clk_in);
      cmp_bit(irq_out, 1'b0);
      wr(CCR_OFS_IRQ_MASK, 8'h00);
      pulse(3'h1);
      cmp_bit(irq_out, 1'b0);
      wr(CCR_OFS_CTL0, 8'h8c);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      k = $urandom & 32'hfc;
      wr(CCR_OFS_CTL0, 8'(k));
      rd(CCR_OFS_CTL0, 8'(k) & 8'h2c);
      wr(CCR_OFS_CTL0, 8'h04);
      wr(CCR_OFS_CTL0, 8'h0c);
      k = $urandom_range(40, 8);
      repeat (k) @(posedge clk_in);
      pulse(3'h2);
      cmp_bit(stamp_we_out, 1'b1);
      cmp_bit(stamp_out + 16'h1 >= 16'((k + 3) / 4) &&
              stamp_out <= 16'((k + 3) / 4 + 1), 1'b1);
      wr(CCR_OFS_CTL0, 8'h04);
      pulse(3'h2);
      cmp_bit(stamp_we_out, 1'b0);
      wr(CCR_OFS_CTL0, 8'h0c);
      pulse(3'h2);
      cmp_bit(stamp_out <= 16'h1, 1'b1);
      wr(CCR_OFS_CTL0, 8'h06);
      bus_idle_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd(CCR_OFS_CTL1, 8'h00);
      bus_idle_in <= 1'b1;
      tx_empty_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd(CCR_OFS_CTL1, 8'h00);
      tx_empty_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd(CCR_OFS_CTL1, 8'h02);
      pulse(3'h4);
      repeat (2) @(posedge clk_in);
      rd(CCR_OFS_CTL1, 8'h00);
      rd(CCR_OFS_CTL0, 8'h04);
      wr(CCR_OFS_CTL0, 8'h02);
      repeat (3) @(posedge clk_in);
      pulse(3'h4);
      rd(CCR_OFS_CTL1, 8'h02);
      wr(CCR_OFS_CTL0, 8'h00);
      repeat (2) @(posedge clk_in);
      rd(CCR_OFS_CTL1, 8'h00);
      wr(CCR_OFS_CTL0, 8'h2d);
      repeat (4) @(negedge clk_in);
      cmp_bit(abort_out, 1'b1);
      rd(CCR_OFS_CTL0, 8'h05);
      rd(CCR_OFS_CTL1, 8'h01);
      cpu_wait_in <= 1'b1;
      pulse(3'h2);
      cmp_bit(stamp_we_out, 1'b0);
      cmp_bit(bus_clk_stop_out, 1'b0);
      repeat (3) @(negedge clk_in);
      stop_test();
   end
endmodule : testbench

bind ccr_ctl0 ccr_ctl0_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .rx_frame_ok_in(rx_frame_ok_in),
   .rx_busy_in(rx_busy_in), .msg_ack_in(msg_ack_in),
   .loopback_in(loopback_in), .cpu_wait_in(cpu_wait_in),
   .abort_out(abort_out), .bus_clk_stop_out(bus_clk_stop_out),
   .stamp_we_out(stamp_we_out));
